// File: rtl/tiwg_pkg.sv
// Purpose: constants and types of the trigger and integration window generator
// Assumes: one sample per CLK_SYS cycle, so Ts is one clock period
// Notes: register map sits in the low 8 address bits of the slave
package tiwg_pkg;
    localparam int unsigned CLK_MHZ = 125;
    localparam int NCH = 8;
    localparam int NBANK = 4;
    localparam int NXB = NBANK - 1;
    // register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_DELAY = 8'h04;
    localparam logic [7:0] A_PERIOD = 8'h08;
    localparam logic [7:0] A_RATE = 8'h0c;
    localparam logic [7:0] A_THRESH = 8'h10;
    localparam logic [7:0] A_STATUS = 8'h14;
    localparam logic [7:0] A_BOXW = 8'h18;
    localparam logic [7:0] A_EVCNT = 8'h1c;
    localparam logic [7:0] A_XB0 = 8'h20;
    localparam logic [7:0] A_XB_STEP = 8'h08;
    // CTRL field positions
    localparam int C_MODE = 0;
    localparam int C_XB = 3;
    localparam int C_BOX = 4;
    localparam int C_BW = 5;
    localparam int C_CHAN = 6;
    // reset values
    localparam logic [15:0] RST_PERIOD = 16'h0004;
    localparam logic [15:0] RST_RATE = 16'h0063;
    // timing: boxcar lags in cycles, pre-trigger history depth, lamp hold
    localparam int GATE_START_LAG = 2;
    localparam int GATE_END_LAG = 3;
    localparam logic [16:0] PRE_LAT = 17'h00010;
    localparam int unsigned LED_HOLD_US = 1000;
    localparam int LED_W = 20;

    typedef enum logic [2:0] {M_EDGE, M_INT, M_LEVEL, M_INPUT, M_PRE} tiwg_mode_t;
    typedef enum logic [1:0] {S_IDLE, S_DLY, S_INT} tiwg_win_t;
    typedef struct packed {
        tiwg_win_t st;
        logic [15:0] cnt;
    } tiwg_tmr_t;
    typedef logic [NCH-1:0][15:0] tiwg_samp_t;

    function automatic logic [15:0] tiwg_pm(input logic [15:0] p);
        return (p == 16'h0000) ? 16'h0001 : p;
    endfunction : tiwg_pm

    function automatic tiwg_tmr_t tiwg_start(input logic [15:0] d, input logic [15:0] p);
        tiwg_tmr_t t;
        t.st = (d == 16'h0000) ? S_INT : S_DLY;
        t.cnt = (d == 16'h0000) ? p - 16'h0001 : d - 16'h0001;
        return t;
    endfunction : tiwg_start

    function automatic tiwg_tmr_t tiwg_step(input tiwg_tmr_t t, input logic [15:0] p);
        tiwg_tmr_t o;
        o = t;
        unique case (t.st)
            S_IDLE: o = t;
            S_DLY: begin
                o.st = (t.cnt == 16'h0000) ? S_INT : S_DLY;
                o.cnt = (t.cnt == 16'h0000) ? p - 16'h0001 : t.cnt - 16'h0001;
            end
            S_INT: begin
                o.st = (t.cnt == 16'h0000) ? S_IDLE : S_INT;
                o.cnt = t.cnt - 16'h0001;
            end
            default: o.st = S_IDLE;
        endcase
        return o;
    endfunction : tiwg_step
endpackage : tiwg_pkg

// File: rtl/tiwg_top.sv
// Purpose: trigger source selection and integration window timing
// Assumes: AHB-Lite slave, zero wait states, OKAY only
// Notes: pre-trigger gates refer to the sample stream delayed by PRE_LAT
//
// Our own choices: the AHB-Lite register port and the address map.
module tiwg_top
    import tiwg_pkg::*;
#(
    parameter int unsigned LED_HOLD_CYC = LED_HOLD_US * CLK_MHZ
) (
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic HRESP,
    output logic [31:0] HRDATA,
    input wire logic TRIG_IN,
    input wire tiwg_samp_t CH_SAMPLE,
    output logic TRIG_OUT,
    output logic [NBANK-1:0] GATE,
    output logic EVT_VALID,
    output logic [15:0] EVT_BOXW,
    output logic LED_ACQ,
    output logic LED_TRIG
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic trig;
        logic trig_d;
        logic [GATE_END_LAG-1:0] bsh;
        logic [2:0] mode;
        logic xb_en;
        logic box_en;
        logic bw_en;
        logic [2:0] chan;
        logic [15:0] dly;
        logic [15:0] per;
        logic [15:0] rate;
        logic [31:0] thr;
        logic [NXB-1:0][15:0] xdly;
        logic [NXB-1:0][15:0] xper;
        tiwg_tmr_t mt;
        tiwg_tmr_t to;
        tiwg_tmr_t [NXB-1:0] xt;
        logic [15:0] rcnt;
        logic [15:0] icnt;
        logic [31:0] acc;
        logic [15:0] bw;
        logic [15:0] bw_last;
        logic [31:0] evcnt;
        logic [LED_W-1:0] la;
        logic [LED_W-1:0] lt;
        logic a_wr;
        logic [7:0] a_addr;
        logic [31:0] hrdata;
        logic hrdy;
        logic trig_out;
        logic evt;
        logic [15:0] evw;
        logic [NBANK-1:0] gate;
        logic hresp;
        logic la_on;
        logic lt_on;
    } tiwg_st_t;

    localparam logic [LED_W-1:0] LED_LOAD = LED_W'(LED_HOLD_CYC);

    tiwg_st_t r;
    tiwg_st_t n;

    always_comb begin
        logic rise;
        logic fall;
        logic tick;
        logic box_win;
        logic boxmode;
        logic busy;
        logic start;
        logic thr_hit;
        logic evt;
        logic [15:0] perm;
        logic [15:0] dpos;
        logic [15:0] dl;
        logic signed [16:0] dpre;
        n = r;
        rise = r.trig & ~r.trig_d;
        fall = ~r.trig & r.trig_d;
        perm = tiwg_pm(r.per);
        start = 1'b0;
        dl = 16'h0000;
        thr_hit = 1'b0;
        tick = 1'b0;
        box_win = 1'b0;
        boxmode = 1'b0;
        busy = 1'b0;
        evt = 1'b0;
        dpos = 16'h0000;
        dpre = 17'sh0;

        // change accepted only when the second and third stages agree
        n.s1 = TRIG_IN;
        n.s2 = r.s1;
        n.s3 = r.s2;
        if (r.s2 == r.s3) begin
            n.trig = r.s3;
        end
        n.trig_d = r.trig;

        // boxcar window: rising edge lags by the start lag, falling by the end lag
        n.bsh = {r.bsh[GATE_END_LAG-2:0], r.trig};
        box_win = r.bsh[GATE_START_LAG-1] | r.bsh[GATE_END_LAG-1];
        boxmode = (r.mode == M_EDGE) && r.box_en;

        busy = (r.mt.st != S_IDLE) || (r.to.st != S_IDLE) || (boxmode && box_win);
        for (int k = 0; k < NXB; k++) begin
            busy = busy || (r.xt[k].st != S_IDLE);
        end

        // free-running internal trigger, one tick every rate+1 cycles
        tick = (r.rcnt == 16'h0000);
        n.rcnt = tick ? r.rate : r.rcnt - 16'h0001;

        // non-overlapping integration blocks of perm samples on one channel
        if ((r.mode == M_INPUT) && !busy) begin
            n.acc = r.acc + 32'(CH_SAMPLE[r.chan]);
            n.icnt = r.icnt + 16'h0001;
            if (r.icnt >= perm - 16'h0001) begin
                thr_hit = (n.acc > r.thr);
                n.acc = 32'h00000000;
                n.icnt = 16'h0000;
            end
        end else begin
            n.acc = 32'h00000000;
            n.icnt = 16'h0000;
        end

        // negative delays clamp to zero outside pre-trigger
        dpos = r.dly[15] ? 16'h0000 : r.dly;
        dpre = $signed(PRE_LAT) + $signed({r.dly[15], r.dly});
        if (dpre < 0) begin
            dpre = 17'sh0;
        end

        case (r.mode)
            M_EDGE: begin
                start = rise && !r.box_en;
                dl = dpos;
            end
            M_INT: start = tick;
            M_LEVEL: start = tick && r.trig;
            M_INPUT: begin
                start = thr_hit;
                dl = dpos;
            end
            M_PRE: begin
                start = rise;
                dl = dpre[15:0];
            end
            default: start = 1'b0;
        endcase
        start = start && !busy;

        n.mt = start ? tiwg_start(dl, perm) : tiwg_step(r.mt, perm);
        // trigger output timer runs from the edge itself, window timer from delay
        if (start && (r.mode == M_PRE)) begin
            n.to = tiwg_start(16'h0000, perm);
        end else begin
            n.to = tiwg_step(r.to, perm);
        end
        for (int k = 0; k < NXB; k++) begin
            if (start && r.xb_en) begin
                n.xt[k] = tiwg_start(r.xdly[k], tiwg_pm(r.xper[k]));
            end else begin
                n.xt[k] = tiwg_step(r.xt[k], tiwg_pm(r.xper[k]));
            end
        end

        // gates: bank 0 is the main bank
        n.gate[0] = boxmode ? box_win : (n.mt.st == S_INT);
        for (int k = 0; k < NXB; k++) begin
            if (boxmode) begin
                n.gate[k+1] = box_win;
            end else if (r.xb_en) begin
                n.gate[k+1] = (n.xt[k].st == S_INT);
            end else begin
                n.gate[k+1] = (n.mt.st == S_INT);
            end
        end

        if (r.mode == M_PRE) begin
            n.trig_out = (n.to.st == S_INT);
        end else if (boxmode) begin
            n.trig_out = box_win;
        end else begin
            n.trig_out = (n.mt.st == S_INT);
        end

        // boxcar width in cycles, saturating
        if (r.trig) begin
            n.bw = (r.bw == 16'hffff) ? r.bw : r.bw + 16'h0001;
        end else begin
            n.bw = 16'h0000;
        end
        if (boxmode && fall) begin
            n.bw_last = r.bw;
        end

        evt = (r.mt.st == S_INT) && (r.mt.cnt == 16'h0000) && !boxmode;
        evt = evt || (boxmode && fall);
        n.evt = evt;
        n.evw = (boxmode && r.bw_en) ? r.bw : 16'h0000;
        if (evt) begin
            n.evcnt = r.evcnt + 32'h00000001;
        end

        // lamps stretched so a single event is visible
        if (evt) begin
            n.la = LED_LOAD;
        end else if (r.la != '0) begin
            n.la = r.la - LED_W'(1);
        end
        if (rise) begin
            n.lt = LED_LOAD;
        end else if (r.lt != '0) begin
            n.lt = r.lt - LED_W'(1);
        end
        // lamp pins registered so a counter decode never glitches them
        n.la_on = (n.la != '0);
        n.lt_on = (n.lt != '0);
        n.hresp = 1'b0;

        // bus: read data captured in the address phase, write in the data phase
        n.hrdy = 1'b1;
        n.a_wr = 1'b0;
        if (HSEL && HREADY && HTRANS[1]) begin
            n.a_wr = HWRITE;
            n.a_addr = HADDR[7:0];
            n.hrdata = 32'h00000000;
            case (HADDR[7:0])
                A_CTRL: begin
                    n.hrdata[C_MODE+:3] = r.mode;
                    n.hrdata[C_XB] = r.xb_en;
                    n.hrdata[C_BOX] = r.box_en;
                    n.hrdata[C_BW] = r.bw_en;
                    n.hrdata[C_CHAN+:3] = r.chan;
                end
                A_DELAY: n.hrdata = {{16{r.dly[15]}}, r.dly};
                A_PERIOD: n.hrdata[15:0] = r.per;
                A_RATE: n.hrdata[15:0] = r.rate;
                A_THRESH: n.hrdata = r.thr;
                A_STATUS: n.hrdata[3:0] = {r.trig_out, r.gate[0], r.trig, busy};
                A_BOXW: n.hrdata[15:0] = r.bw_last;
                A_EVCNT: n.hrdata = r.evcnt;
                default: begin
                    for (int k = 0; k < NXB; k++) begin
                        if (HADDR[7:0] == A_XB0 + 8'(k) * A_XB_STEP) begin
                            n.hrdata[15:0] = r.xdly[k];
                        end
                        if (HADDR[7:0] == A_XB0 + 8'(k) * A_XB_STEP + 8'h04) begin
                            n.hrdata[15:0] = r.xper[k];
                        end
                    end
                end
            endcase
        end
        if (r.a_wr) begin
            case (r.a_addr)
                A_CTRL: begin
                    n.mode = HWDATA[C_MODE+:3];
                    n.xb_en = HWDATA[C_XB];
                    n.box_en = HWDATA[C_BOX];
                    n.bw_en = HWDATA[C_BW];
                    n.chan = HWDATA[C_CHAN+:3];
                end
                A_DELAY: n.dly = HWDATA[15:0];
                A_PERIOD: n.per = HWDATA[15:0];
                A_RATE: n.rate = HWDATA[15:0];
                A_THRESH: n.thr = HWDATA;
                default: begin
                    for (int k = 0; k < NXB; k++) begin
                        if (r.a_addr == A_XB0 + 8'(k) * A_XB_STEP) begin
                            n.xdly[k] = HWDATA[15:0];
                        end
                        if (r.a_addr == A_XB0 + 8'(k) * A_XB_STEP + 8'h04) begin
                            n.xper[k] = HWDATA[15:0];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            r <= '0;
            r.per <= RST_PERIOD;
            r.rate <= RST_RATE;
            r.hrdy <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign HREADYOUT = r.hrdy;
    assign HRESP = r.hresp;
    assign HRDATA = r.hrdata;
    assign TRIG_OUT = r.trig_out;
    assign GATE = r.gate;
    assign EVT_VALID = r.evt;
    assign EVT_BOXW = r.evw;
    assign LED_ACQ = r.la_on;
    assign LED_TRIG = r.lt_on;
endmodule : tiwg_top

// File: dv/tiwg_monitor.sv
// Purpose: port-level checks of tiwg_top
// Assumes: lamp hold of at least four cycles
// Notes: mode is not visible at the ports, so checks stay mode-free
module tiwg_monitor
    import tiwg_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    input wire logic HSEL,
    input wire logic [1:0] HTRANS,
    input wire logic HREADY,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic [31:0] HRDATA,
    input wire logic TRIG_IN,
    input wire logic TRIG_OUT,
    input wire logic [NBANK-1:0] GATE,
    input wire logic EVT_VALID,
    input wire logic LED_ACQ,
    input wire logic LED_TRIG
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!ARST_N);
    sequence pin_rise;
        $rose(TRIG_IN) && !LED_TRIG;
    endsequence
    sequence lamp_lit;
        LED_TRIG [*3];
    endsequence
    bus_okay_a: assert property (HREADYOUT && !HRESP)
        else $error("bus answer not OKAY");
    rdata_hold_a: assert property (!$past(HSEL && HREADY && HTRANS[1]) |-> $stable(HRDATA))
        else $error("read data moved without a transfer");
    evt_pulse_a: assert property (EVT_VALID |=> !EVT_VALID)
        else $error("event strobe longer than one cycle");
    acq_lamp_a: assert property (EVT_VALID |-> ##[0:2] LED_ACQ)
        else $error("acquisition lamp not lit after event");
    acq_hold_a: assert property ($rose(LED_ACQ) |=> LED_ACQ [*3])
        else $error("acquisition lamp dropped early");
    trig_lamp_a: assert property (pin_rise |-> ##[2:8] lamp_lit)
        else $error("trigger lamp not lit after pin rise");
    sync_lag_a: assert property (pin_rise |=> !LED_TRIG [*2])
        else $error("pin rise seen before synchroniser");
    evt_window_a: assert property (EVT_VALID |-> (GATE != 0) || TRIG_OUT
        || $past(GATE != 0) || $past(TRIG_OUT))
        else $error("event strobe without a window");
endmodule : tiwg_monitor

// File: dv/tiwg_src.sv
// Purpose: trigger pin and channel sample source facing tiwg_top
// Assumes: the bench calls the tasks here by hierarchical name
// Notes: idle channels carry a moving pattern so a stale value never hides
module tiwg_src
    import tiwg_pkg::*;
(
    input wire logic clk,
    output logic trig,
    output tiwg_samp_t samp
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] lvl = 16'h0000;
    logic [15:0] noise = 16'h0000;
    int ch = 0;
    initial trig = 1'b0;
    initial samp = '0;
    always @(posedge clk) begin
        noise <= noise + 16'h0001;
        for (int i = 0; i < NCH; i++) begin
            samp[i] <= (i == ch) ? lvl : noise;
        end
    end
    task automatic level(input logic v);
        @(posedge clk);
        trig <= v;
    endtask : level
    // pin changes on clock edges, so widths are exact in cycles
    task automatic pulse(input int w);
        level(1'b1);
        repeat (w - 1) @(posedge clk);
        level(1'b0);
    endtask : pulse
    task automatic burst(input logic [15:0] v, input int n);
        @(posedge clk);
        lvl <= v;
        repeat (n) @(posedge clk);
        lvl <= 16'h0000;
    endtask : burst
endmodule : tiwg_src

// File: dv/tiwg_bench.sv
// Purpose: self-checking bench for tiwg_top
// Assumes: lamp hold cut to 4 cycles
// Notes: latencies compared as differences, so pipeline depth cancels
module tiwg_bench
    import tiwg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic arst_n;
    logic hs;
    logic [1:0] ht;
    logic [31:0] ha;
    logic hw;
    logic [2:0] hsz;
    logic [31:0] hwd;
    logic [31:0] rd;
    int lat0 = 0;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic hro, hresp, tout, ev, led_a, led_t, trig;
    logic [31:0] hrd;
    logic [NBANK-1:0] gate;
    logic [15:0] boxw;
    tiwg_samp_t samp;
    wire logic [4:0] obs = {gate, tout};
    tiwg_src src (.clk(clk), .trig(trig), .samp(samp));
    tiwg_top #(.LED_HOLD_CYC(4)) dut (.CLK_SYS(clk), .ARST_N(arst_n), .HSEL(hs),
        .HADDR(ha), .HTRANS(ht), .HWRITE(hw), .HSIZE(hsz), .HWDATA(hwd),
        .HREADY(hro), .HREADYOUT(hro), .HRESP(hresp), .HRDATA(hrd),
        .TRIG_IN(trig), .CH_SAMPLE(samp), .TRIG_OUT(tout), .GATE(gate),
        .EVT_VALID(ev), .EVT_BOXW(boxw), .LED_ACQ(led_a), .LED_TRIG(led_t));
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %0h seen %0h", n, exp, got);
        end
    endtask : chk
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        hs <= 1'b1;
        ht <= 2'h2;
        ha <= {24'h0, a};
        hw <= w;
        hsz <= 3'h2;
        do @(posedge clk); while (hro !== 1'b1);
        hs <= 1'b0;
        ht <= 2'h0;
        hwd <= d;
        do @(posedge clk); while (hro !== 1'b1);
        rd = hrd;
    endtask : bus
    // bit b of obs: latency to rise and high width, both in cycles
    task automatic meas(input int b, output int l, output int w);
        l = 0;
        w = 0;
        while (obs[b] !== 1'b1 && l < 300) begin
            @(negedge clk);
            l++;
        end
        while (obs[b] === 1'b1 && w < 300) begin
            @(negedge clk);
            w++;
        end
    endtask : meas
    task automatic t_regs;
        bus(A_PERIOD, 1'b0, 32'h0);
        chk("period reset", rd[15:0], RST_PERIOD);
        bus(A_RATE, 1'b0, 32'h0);
        chk("rate reset", rd[15:0], RST_RATE);
        bus(8'h40, 1'b1, 32'h5a5a);
        bus(8'h40, 1'b0, 32'h0);
        chk("unmapped read", rd, 32'h0);
        bus(A_PERIOD, 1'b1, 32'h5);
    endtask : t_regs
    task automatic t_edge;
        int l0, w0, l1, w1, l2, w2, n;
        bus(A_CTRL, 1'b1, 32'h0);
        fork src.pulse(3); meas(0, l0, w0); meas(1, l2, w2); join
        lat0 = l0;
        chk("edge width", w0, 5);
        chk("out is main window", l2, l0);
        bus(A_DELAY, 1'b1, 32'h3);
        bus(A_EVCNT, 1'b0, 32'h0);
        n = rd;
        fork
            begin src.pulse(3); repeat (3) @(posedge clk); src.pulse(3); end
            meas(1, l1, w1);
        join
        repeat (30) @(posedge clk);
        bus(A_EVCNT, 1'b0, 32'h0);
        chk("one event per window", rd - n, 1);
        chk("edge delay shift", l1 - l0, 3);
        chk("edge width delayed", w1, 5);
        bus(A_DELAY, 1'b1, -32'sd4);
        fork src.pulse(3); meas(0, l1, w1); join
        chk("negative delay clamped", l1, l0);
    endtask : t_edge
    task automatic t_pre;
        int dl[2] = '{-4, 3};
        int lo, wo, lg, wg;
        bus(A_CTRL, 1'b1, 32'h4);
        for (int i = 0; i < 2; i++) begin
            bus(A_DELAY, 1'b1, dl[i]);
            fork src.pulse(3); meas(0, lo, wo); meas(1, lg, wg); join
            // output must rise as soon as an undelayed edge window would
            chk("pre out lead", lo, lat0);
            chk("pre out width", wo, 5);
            chk("pre window place", lg - lo, PRE_LAT + dl[i]);
            chk("pre window width", wg, 5);
        end
    endtask : t_pre
    task automatic t_tick;
        int la, wa, lb, wb;
        bus(A_DELAY, 1'b1, 32'h0);
        bus(A_RATE, 1'b1, 32'h9);
        bus(A_CTRL, 1'b1, 32'h2);
        meas(0, la, wa);
        chk("gate low blocks", wa, 0);
        src.level(1'b1);
        meas(0, la, wa);
        meas(0, lb, wb);
        chk("gated tick spacing", wa + lb, 10);
        src.level(1'b0);
        bus(A_CTRL, 1'b1, 32'h1);
        // a level window may still be open here, so skip to a whole one
        meas(0, la, wa);
        meas(0, la, wa);
        meas(0, lb, wb);
        chk("internal spacing", wa + lb, 10);
        bus(A_CTRL, 1'b1, 32'h7);
        repeat (20) @(posedge clk);
    endtask : t_tick
    task automatic t_input;
        int l0, w0, l3, w3;
        src.ch = 5;
        bus(A_PERIOD, 1'b1, 32'h2);
        bus(A_DELAY, 1'b1, 32'h1);
        bus(A_THRESH, 1'b1, 32'd100);
        bus(A_CTRL, 1'b1, 32'h143);
        fork src.burst(16'd40, 4); meas(1, l0, w0); join
        chk("below threshold", w0, 0);
        fork src.burst(16'd60, 4); meas(1, l0, w0); meas(4, l3, w3); join
        chk("threshold window", w0, 2);
        chk("all banks together", l3, l0);
    endtask : t_input
    task automatic t_cross;
        int lo, wo, lx, wx;
        bus(A_PERIOD, 1'b1, 32'h5);
        bus(A_DELAY, 1'b1, 32'h0);
        bus(A_XB0, 1'b1, 32'h2);
        bus(A_XB0 + 8'h04, 1'b1, 32'h3);
        bus(A_CTRL, 1'b1, 32'h8);
        fork src.pulse(3); meas(0, lo, wo); meas(2, lx, wx); join
        chk("bank delay", lx - lo, 2);
        chk("bank period", wx, 3);
        chk("out shows main", wo, 5);
    endtask : t_cross
    task automatic t_box;
        int l, w, lb, wb;
        logic [15:0] bw;
        bus(A_CTRL, 1'b1, 32'h30);
        fork
            src.pulse(20);
            meas(1, l, w);
            meas(4, lb, wb);
            begin
                for (int i = 0; i < 80 && ev !== 1'b1; i++) @(negedge clk);
                bw = boxw;
            end
        join
        chk("boxcar width value", bw, 16'd20);
        chk("boxcar window", w, 20 + GATE_END_LAG - GATE_START_LAG);
        chk("boxcar all banks", wb, w);
        bus(A_BOXW, 1'b0, 32'h0);
        chk("boxcar width reg", rd[15:0], 16'd20);
    endtask : t_box
    task complete_run;
        $display("checks %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run
    initial begin
        arst_n <= 1'b0;
        hs <= 1'b0;
        ht <= 2'h0;
        ha <= 32'h0;
        hw <= 1'b0;
        hsz <= 3'h2;
        hwd <= 32'h0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        t_regs();
        t_edge();
        t_pre();
        t_tick();
        t_input();
        t_cross();
        t_box();
        complete_run();
    end
endmodule : tiwg_bench
bind tiwg_top tiwg_monitor mon (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .HSEL(HSEL),
    .HTRANS(HTRANS), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .HRDATA(HRDATA), .TRIG_IN(TRIG_IN), .TRIG_OUT(TRIG_OUT), .GATE(GATE),
    .EVT_VALID(EVT_VALID), .LED_ACQ(LED_ACQ), .LED_TRIG(LED_TRIG));
